// File: rtl/cmpd_pkg.sv
package cmpd_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [3:0] CMPD_CTRL_OFS = 4'h0;
    localparam logic [3:0] CMPD_MODE_OFS = 4'h4;
    localparam int CMPD_ADDR_W = 4;

    // control register field positions
    localparam int CMPD_EN_BIT = 7;
    localparam int CMPD_OUT_BIT = 6;
    localparam int CMPD_RISE_BIT = 5;
    localparam int CMPD_FALL_BIT = 4;
    localparam int CMPD_HYP_LSB = 2;
    localparam int CMPD_HYN_LSB = 0;
    localparam int CMPD_HYST_W = 2;
    localparam int CMPD_MODE_W = 2;

    // reset values
    localparam logic [CMPD_HYST_W-1:0] CMPD_HYST_RST = 2'h0;
    localparam logic [CMPD_MODE_W-1:0] CMPD_MODE_RST = 2'h2;

    // axi response codes
    localparam logic [1:0] CMPD_RESP_OKAY = 2'h0;
    localparam logic [1:0] CMPD_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CMPD_HYST_OFF = 2'b00,
        CMPD_HYST_5MV = 2'b01,
        CMPD_HYST_10MV = 2'b10,
        CMPD_HYST_20MV = 2'b11
    } cmpd_hyst_e;

    typedef enum logic [1:0] {
        CMPD_MODE0 = 2'b00,
        CMPD_MODE1 = 2'b01,
        CMPD_MODE2 = 2'b10,
        CMPD_MODE3 = 2'b11
    } cmpd_mode_e;
endpackage

// File: rtl/cmpd_top.sv
// Operation
// R1 - latched and raw outputs offered to pins
// R2 - raw output works without any clock
// R3 - disabled: pin outputs low, core unpowered
// R4 - software selects response time mode
// R5 - hysteresis set by control bits three..zero
// R6 - negative hysteresis: off, 5, 10, 20 mV
// R7 - positive hysteresis field, same four choices
// R8 - falling transition sets falling flag
// R9 - rising transition sets rising flag
// R10 - flags stay until software clears
// R11 - interrupt request on either edge
// R12 - state bit reads current output
// R13 - enable bit turns comparator on/off
// R14 - spurious edges may be flagged
// R15 - software clears flags after setting changes
// R16 - comparator output offered as reset source
// R17 - control register bit layout as shown
// R18 - mode field codes, reset to two
// R19 - two-stage synchroniser, edges from samples
// R20 - hardware set beats software clear
module cmpd_top
    import cmpd_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [CMPD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CMPD_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic core_out,
    output logic core_power_en,
    output logic [CMPD_HYST_W-1:0] pos_hyst_sel,
    output logic [CMPD_HYST_W-1:0] neg_hyst_sel,
    output logic [CMPD_MODE_W-1:0] response_mode_sel,
    output logic latched_cmp_out,
    output logic raw_cmp_out,
    output logic cmp_reset_src,
    output logic cmp_irq
);
    logic cmp_enable_bit;
    logic rise_edge_flag;
    logic fall_edge_flag;
    localparam int SYNC_MIN = 2;
    localparam int SYNC_MAX = 4;
    localparam int REG_W = 8;

    typedef enum logic [1:0] {
        CMPD_SEL_NONE = 2'b00,
        CMPD_SEL_CTRL = 2'b01,
        CMPD_SEL_MODE = 2'b10
    } cmpd_sel_e;

    logic [SYNC_STAGES-1:0] sync_q;
    logic sync_out;
    logic latched_prev;
    logic edge_evt [0:1];
    logic edge_wbit [0:1];
    logic edge_flag [0:1];
    logic rd_take;
    logic aw_held;
    logic w_held;
    logic [CMPD_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_ctrl;
    logic wr_mode;
    logic rise_evt;
    logic fall_evt;
    logic [7:0] cmp_control_reg;
    logic [7:0] cmp_response_mode_reg;

    function automatic logic hit(input logic [CMPD_ADDR_W-1:0] a,
                                 input logic [CMPD_ADDR_W-1:0] ofs);
        hit = (a[CMPD_ADDR_W-1:2] == ofs[CMPD_ADDR_W-1:2]);
    endfunction

    // register select from the word address; byte lane bits are ignored
    function automatic cmpd_sel_e decode(input logic [CMPD_ADDR_W-1:0] a);
        if (hit(a, CMPD_CTRL_OFS)) begin
            decode = CMPD_SEL_CTRL;
        end else if (hit(a, CMPD_MODE_OFS)) begin
            decode = CMPD_SEL_MODE;
        end else begin
            decode = CMPD_SEL_NONE;
        end
    endfunction

    // both registers answer; every other word is refused with an error
    function automatic logic mapped(input logic [CMPD_ADDR_W-1:0] a);
        mapped = (decode(a) != CMPD_SEL_NONE);
    endfunction

    // fewer stages would let a metastable sample reach the edge detector
    if (SYNC_STAGES < SYNC_MIN) begin : g_sync_low
        $error("cmpd_top needs at least two synchroniser stages");
    end

    // more stages only add latency to the latched output, the reset source, the state bit and the flags
    if (SYNC_STAGES > SYNC_MAX) begin : g_sync_high
        $error("cmpd_top synchroniser deeper than four stages");
    end

    // the control image must fit in the low byte of the bus word
    if (CMPD_EN_BIT >= REG_W) begin : g_layout_check
        $error("cmpd_top control layout wider than one byte");
    end

    // word select needs address bits above the byte lane
    if (CMPD_ADDR_W < 3) begin : g_addr_check
        $error("cmpd_top address too narrow for two registers");
    end

    // raw path is purely combinational so it runs with the clock stopped
    assign raw_cmp_out = core_out & cmp_enable_bit; // [R1] [R2] [R3]
    assign core_power_en = cmp_enable_bit; // [R3] [R13]

    // only the first stage reads the pin; the rest of the chain follows it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_q <= '0;
        end else if (clk_en) begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], core_out}; // [R19]
        end
    end

    assign sync_out = sync_q[SYNC_STAGES-1];

    // gated by enable so a disabled core gives no pin level
    assign latched_cmp_out = sync_out & cmp_enable_bit; // [R1] [R3]
    assign cmp_reset_src = latched_cmp_out; // [R16]

    // previous sample of the gated output, for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_prev <= 1'b0;
        end else if (clk_en) begin
            latched_prev <= latched_cmp_out; // [R19]
        end
    end

    // edges of the gated output: disabling while the output is high sets the fall flag,
    // and enabling with the input high sets the rise flag, hence clearing after setup
    assign rise_evt = latched_cmp_out & ~latched_prev; // [R9] [R14] [R19]
    assign fall_evt = ~latched_cmp_out & latched_prev; // [R8] [R14] [R19]

    // write channel capture: address and data in either order
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_go = aw_held & w_held & ~s_axi_bvalid;
    assign wr_ctrl = wr_go & (decode(aw_addr) == CMPD_SEL_CTRL) & w_strb[0];
    assign wr_mode = wr_go & (decode(aw_addr) == CMPD_SEL_MODE) & w_strb[0];

    // address holder: keeps the address until its data has arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
        end
    end

    // data holder: keeps data and strobes until the address has arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // one response per write; a refused word still answers, with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CMPD_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? CMPD_RESP_OKAY : CMPD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // enable also gates power to the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_enable_bit <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            cmp_enable_bit <= w_data[CMPD_EN_BIT]; // [R13] [R17]
        end
    end

    // hysteresis changes may flag a false edge; software clears afterwards
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_hyst_sel <= CMPD_HYST_RST;
        end else if (clk_en && wr_ctrl) begin
            pos_hyst_sel <= w_data[CMPD_HYP_LSB +: CMPD_HYST_W]; // [R5] [R7] [R17]
        end
    end

    // negative side is set on its own, same four codes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            neg_hyst_sel <= CMPD_HYST_RST;
        end else if (clk_en && wr_ctrl) begin
            neg_hyst_sel <= w_data[CMPD_HYN_LSB +: CMPD_HYST_W]; // [R5] [R6] [R17]
        end
    end

    // mode resets to code two, not to the fastest setting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            response_mode_sel <= CMPD_MODE_RST; // [R18]
        end else if (clk_en && wr_mode) begin
            response_mode_sel <= w_data[CMPD_MODE_W-1:0]; // [R4] [R18]
        end
    end

    // sticky edge flags; writing 0 clears, writing 1 leaves as is
    assign edge_evt[0] = rise_evt;
    assign edge_evt[1] = fall_evt;
    assign edge_wbit[0] = w_data[CMPD_RISE_BIT];
    assign edge_wbit[1] = w_data[CMPD_FALL_BIT];

    // set is tested first so an edge in the clearing cycle is not lost
    for (genvar f = 0; f < 2; f++) begin : g_flag
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                edge_flag[f] <= 1'b0;
            end else if (clk_en) begin
                if (edge_evt[f]) begin
                    edge_flag[f] <= 1'b1; // [R8] [R9] [R20]
                end else if (wr_ctrl && !edge_wbit[f]) begin
                    edge_flag[f] <= 1'b0; // [R10]
                end
            end
        end
    end

    assign rise_edge_flag = edge_flag[0]; // [R9]
    assign fall_edge_flag = edge_flag[1]; // [R8]

    // level request: stays up as long as either flag does
    assign cmp_irq = rise_edge_flag | fall_edge_flag; // [R11]

    always_comb begin
        cmp_control_reg = '0;
        cmp_control_reg[CMPD_EN_BIT] = cmp_enable_bit;
        cmp_control_reg[CMPD_OUT_BIT] = latched_cmp_out; // [R12]
        cmp_control_reg[CMPD_RISE_BIT] = rise_edge_flag;
        cmp_control_reg[CMPD_FALL_BIT] = fall_edge_flag;
        cmp_control_reg[CMPD_HYP_LSB +: CMPD_HYST_W] = pos_hyst_sel;
        cmp_control_reg[CMPD_HYN_LSB +: CMPD_HYST_W] = neg_hyst_sel;
    end

    always_comb begin
        cmp_response_mode_reg = '0;
        cmp_response_mode_reg[CMPD_MODE_W-1:0] = response_mode_sel;
    end

    // read channel: one read at a time
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;

    // valid stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (clk_en) begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // refused reads answer with an error and a zero word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rresp <= CMPD_RESP_OKAY;
        end else if (clk_en && rd_take) begin
            s_axi_rresp <= mapped(s_axi_araddr) ? CMPD_RESP_OKAY : CMPD_RESP_SLVERR;
        end
    end

    // data captured with the request, so it stands while valid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
        end else if (clk_en && rd_take) begin
            unique case (decode(s_axi_araddr))
                CMPD_SEL_CTRL: begin
                    s_axi_rdata <= {24'h000000, cmp_control_reg}; // [R12] [R17]
                end
                CMPD_SEL_MODE: begin
                    s_axi_rdata <= {24'h000000, cmp_response_mode_reg}; // [R18]
                end
                default: begin
                    s_axi_rdata <= '0;
                end
            endcase
        end
    end
endmodule

// File: tb/cmpd_core_model.sv
module cmpd_core_model (
    input wire logic core_power_en,
    input wire logic level,
    output logic core_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // unpowered core has no valid result: show the inverse, not a kind zero
    assign core_out = core_power_en ? level : ~level;
endmodule

// File: tb/cmpd_chk.sv
module cmpd_chk
    import cmpd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_out,
    input wire logic core_power_en,
    input wire logic [1:0] pos_hyst_sel,
    input wire logic [1:0] neg_hyst_sel,
    input wire logic [1:0] response_mode_sel,
    input wire logic latched_cmp_out,
    input wire logic raw_cmp_out,
    input wire logic cmp_reset_src,
    input wire logic cmp_irq,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_raw_gated: assert property (raw_cmp_out == (core_out & core_power_en))
        else $error("raw output not gated by enable");
    a_latched_off: assert property (!core_power_en |-> !latched_cmp_out)
        else $error("latched output high while disabled");
    a_reset_src: assert property (cmp_reset_src == latched_cmp_out)
        else $error("reset source differs from output");
    a_rise_flag: assert property ($rose(latched_cmp_out) && $past(core_power_en) |-> ##[0:2] cmp_irq)
        else $error("rising edge raised no request");
    a_fall_flag: assert property ($fell(latched_cmp_out) && core_power_en |-> ##[0:2] cmp_irq)
        else $error("falling edge raised no request");
    a_flag_sticky: assert property (cmp_irq |=> cmp_irq || $rose(s_axi_bvalid))
        else $error("edge flag dropped without a write");
    a_mode_reset: assert property ($rose(aresetn) |-> response_mode_sel == 2'h2)
        else $error("mode field reset value wrong");
    a_enable_write: assert property (!$rose(s_axi_bvalid) |-> $stable(core_power_en))
        else $error("enable changed without a write");
    a_hyst_write: assert property (!$rose(s_axi_bvalid) |-> $stable({pos_hyst_sel, neg_hyst_sel}))
        else $error("hysteresis changed without a write");
    c_irq: cover property ($rose(cmp_irq));
    c_fall: cover property ($fell(latched_cmp_out));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind cmpd_top cmpd_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .core_out(core_out), .core_power_en(core_power_en),
    .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
    .response_mode_sel(response_mode_sel), .latched_cmp_out(latched_cmp_out),
    .raw_cmp_out(raw_cmp_out), .cmp_reset_src(cmp_reset_src), .cmp_irq(cmp_irq),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp)
);

// File: tb/tb_cmpd_top.sv
module tb_cmpd_top
    import cmpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, level = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_out;
    logic core_power_en, latched_cmp_out, raw_cmp_out, cmp_reset_src, cmp_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, pos_hyst_sel, neg_hyst_sel, response_mode_sel;
    int err_count = 0;
    int n_tests = 0;
    cmpd_top uut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .core_out(core_out), .core_power_en(core_power_en),
        .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
        .response_mode_sel(response_mode_sel), .latched_cmp_out(latched_cmp_out),
        .raw_cmp_out(raw_cmp_out), .cmp_reset_src(cmp_reset_src), .cmp_irq(cmp_irq)
    );
    cmpd_core_model u_core (.core_power_en(core_power_en), .level(level), .core_out(core_out));
    always #25 aclk = ~aclk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic tmo();
        $display("FAIL bus wait expected answer seen none");
        err_count++;
        complete_run();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [1:0] eb;
        eb = (a == CMPD_CTRL_OFS || a == CMPD_MODE_OFS) ? CMPD_RESP_OKAY : CMPD_RESP_SLVERR;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'h0;
                chk("bresp", {30'h0, eb}, {30'h0, s_axi_bresp});
                return;
            end
        end
        tmo();
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'h0;
                chk("rdata", e, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                return;
            end
        end
        tmo();
    endtask
    task automatic t_reset();
        rd(CMPD_CTRL_OFS, 32'h0, CMPD_RESP_OKAY);
        rd(CMPD_MODE_OFS, 32'h2, CMPD_RESP_OKAY);
        chk("core_power_en", 32'h0, {31'h0, core_power_en});
        $display("reset values done");
    endtask
    task automatic t_edges();
        level <= 1'h1;
        wr(CMPD_CTRL_OFS, 8'h80);
        repeat (6) @(posedge aclk);
        chk("pins", 32'h7, {29'h0, raw_cmp_out, latched_cmp_out, core_power_en});
        rd(CMPD_CTRL_OFS, 32'hE0, CMPD_RESP_OKAY);
        rd(CMPD_CTRL_OFS, 32'hE0, CMPD_RESP_OKAY);
        wr(CMPD_CTRL_OFS, 8'h80);
        rd(CMPD_CTRL_OFS, 32'hC0, CMPD_RESP_OKAY);
        level <= 1'h0;
        repeat (6) @(posedge aclk);
        chk("cmp_irq", 32'h1, {31'h0, cmp_irq});
        rd(CMPD_CTRL_OFS, 32'h90, CMPD_RESP_OKAY);
        wr(CMPD_CTRL_OFS, 8'h80);
        chk("cmp_irq", 32'h0, {31'h0, cmp_irq});
        $display("edge flags done");
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            wr(CMPD_CTRL_OFS, 8'h80 | 8'(i << 2) | 8'(3 - i));
            chk("hyst", 32'(i * 4 + 3 - i), {28'h0, pos_hyst_sel, neg_hyst_sel});
            wr(CMPD_MODE_OFS, 8'(i));
            chk("mode", 32'(i), {30'h0, response_mode_sel});
        end
        rd(4'h8, 32'h0, CMPD_RESP_SLVERR);
        wr(4'h8, 8'hFF);
        chk("mode kept", 32'h3, {30'h0, response_mode_sel});
        $display("settings done");
    endtask
    task automatic t_off();
        level <= 1'h1;
        wr(CMPD_CTRL_OFS, 8'h00);
        repeat (4) @(posedge aclk);
        chk("off pins", 32'h0, {29'h0, raw_cmp_out, latched_cmp_out, core_power_en});
        wr(CMPD_CTRL_OFS, 8'h80);
        clk_en <= 1'h0;
        level <= 1'h0;
        @(posedge aclk);
        chk("raw stopped", 32'h0, {31'h0, raw_cmp_out});
        level <= 1'h1;
        @(posedge aclk);
        chk("raw stopped", 32'h1, {31'h0, raw_cmp_out});
        clk_en <= 1'h1;
        $display("disable and stop done");
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_edges();
        t_fields();
        t_off();
        complete_run();
    end
endmodule
